// [hdl/tpwm_pkg.sv]
// Constants and types shared by the triangle PWM channel files.
`default_nettype none
package tpwm_pkg;
    localparam int unsigned TPWM_CW        = 32;
    localparam int unsigned TPWM_NCH       = 3;
    localparam logic [31:0] TPWM_ZERO      = 32'h0000_0000;
    localparam logic [31:0] TPWM_ONE       = 32'h0000_0001;
    localparam logic [31:0] TPWM_PR_RST    = 32'h0000_FFFF;
    localparam logic        TPWM_POS_START = 1'b1;
    localparam logic        TPWM_NEG_START = 1'b0;
    typedef enum logic [2:0] {
        TPWM_IDLE = 3'b001,
        TPWM_UP   = 3'b010,
        TPWM_DOWN = 3'b100
    } tpwm_state_t;
endpackage : tpwm_pkg
`default_nettype wire

// [hdl/tpwm_dead.sv]
// Automatic dead time: derives the negative compare from the positive one.
`default_nettype none
module tpwm_dead
    import tpwm_pkg::*;
#(
    parameter int unsigned W = TPWM_CW
) (
    input  wire logic [W-1:0] pos_cmp,
    input  wire logic [W-1:0] dt_first,
    input  wire logic [W-1:0] dt_second,
    output logic      [W-1:0] neg_first,
    output logic      [W-1:0] neg_second,
    output logic              dt_error
);
    // The negative phase switches a dead time below the positive compare.
    always_comb begin
        dt_error = (pos_cmp < dt_first) || (pos_cmp < dt_second); // R22
        neg_first = dt_error ? {W{1'b0}} : pos_cmp - dt_first; // R20
        neg_second = dt_error ? {W{1'b0}} : pos_cmp - dt_second; // R20
    end
endmodule : tpwm_dead
`default_nettype wire

// [hdl/tpwm_buf.sv]
// Double buffer with temporary stage for one compare register.
`default_nettype none
module tpwm_buf
    import tpwm_pkg::*;
#(
    parameter int unsigned W = TPWM_CW
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         ce,
    input  wire logic         crest,
    input  wire logic         trough,
    input  wire logic         force_xfer,
    input  wire logic [W-1:0] first_buf,
    input  wire logic [W-1:0] second_buf,
    output logic      [W-1:0] cmp_q
);
    logic [W-1:0] temp_q;

    // Crest moves the temporary; trough moves both buffers as one transfer.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            temp_q <= '0;
            cmp_q  <= '0;
        end else if (ce) begin
            if (force_xfer || trough) begin
                temp_q <= second_buf; // R10
                cmp_q  <= first_buf; // R11
            end else if (crest) begin
                cmp_q <= temp_q; // R11
            end
        end
    end
endmodule : tpwm_buf
`default_nettype wire

// [hdl/tpwm_channel.sv]
// One channel of the triangle-wave complementary PWM timer.
// How it works
// R1: One start write starts every flagged channel on the same clock.
// R2: With auto dead time, negative compare follows each positive update.
// R3: Software keeps positive compare above dead times and below period.
// R4: Positive compare zero or above period while running trips protection, with auto dead time only.
// R5: Software loads positive compare in range before counting starts.
// R6: Without auto dead time, software keeps both compares in range.
// R7: Compare zero or equal period matches once, at zero or period.
// R8: Compare above period never matches.
// R9: Channels give complementary pairs with dead time between edges.
// R10: Both buffer words move together at the trough.
// R11: Crest loads temp into compare; trough loads buffers.
// R12: Negative compare has its own double buffer pair.
// R13: Forced transfer copies buffers into temp and compare at once.
// R14: Positive pin high at start and stop, toggles on match.
// R15: Negative pin low at start and stop, toggles on match.
// R16: Counter starts at zero, counts up to period, then down.
// R17: Trough pulse raised so software can reload buffers.
// R18: Negative output goes off before positive comes on.
// R19: Separate up and down compares make asymmetric pulses.
// R20: First and second half dead times are applied separately.
// R21: Dead time buffers move to active values at each trough.
// R22: Negative dead time underflow corrects both phase edges.
// R23: Without auto dead time, negative compare buffers like positive.
// R24: Crest pulse raised when the counter reverses at period.
`default_nettype none
module tpwm_channel
    import tpwm_pkg::*;
#(
    parameter int unsigned W  = TPWM_CW,
    parameter int unsigned CH = 0
) (
    input  wire logic                        clk,
    input  wire logic                        nrst,
    input  wire logic                        ce,
    input  wire logic [tpwm_pkg::TPWM_NCH-1:0] start_bits,
    input  wire logic                        start_wr,
    input  wire logic [tpwm_pkg::TPWM_NCH-1:0] stop_bits,
    input  wire logic                        stop_wr,
    input  wire logic                        auto_dead_en,
    input  wire logic                        force_xfer,
    input  wire logic [W-1:0]                period_register,
    input  wire logic [W-1:0]                positive_first_buffer,
    input  wire logic [W-1:0]                positive_second_buffer,
    input  wire logic [W-1:0]                negative_first_buffer,
    input  wire logic [W-1:0]                negative_second_buffer,
    input  wire logic [W-1:0]                first_half_dead_time_buffer,
    input  wire logic [W-1:0]                second_half_dead_time_buffer,
    output logic                             positive_phase_pin,
    output logic                             negative_phase_pin,
    output logic                             trough_interrupt,
    output logic                             crest_interrupt,
    output logic                             protect_trip,
    output logic                             dead_time_error,
    output logic                             running,
    output logic [W-1:0]                     carrier_counter,
    output logic [W-1:0]                     positive_compare,
    output logic [W-1:0]                     negative_compare
);
    tpwm_state_t  st_q;
    logic [W-1:0] cnt_q;
    logic [W-1:0] dvu_q;
    logic [W-1:0] dvd_q;
    logic [W-1:0] nb_cmp;
    logic [W-1:0] nauto_up;
    logic [W-1:0] nauto_dn;
    logic         dt_err;
    logic         start_me;
    logic         stop_me;
    logic         crest;
    logic         trough;
    logic         up;
    logic         pmatch;
    logic         nmatch;
    logic         pos_q;
    logic         neg_q;
    logic         pos_d;
    logic         neg_d;
    logic         trip_q;
    logic         started_q;

    function automatic logic hit(input logic [W-1:0] c,
                                 input logic [W-1:0] n,
                                 input logic [W-1:0] p);
        // A value above period is never reached.
        hit = (c <= p) && (n == c); // R8
    endfunction : hit

    function automatic logic may_flip(input logic lvl,
                                      input logic other,
                                      input logic free);
        // Outputs are active low: a pin may rise freely, fall only
        // while its partner is high or when free is set.
        may_flip = free || !lvl || other; // R18
    endfunction : may_flip

    function automatic logic bad_cmp(input logic [W-1:0] c,
                                     input logic [W-1:0] p);
        // Zero or a value beyond the period cannot place a valid edge.
        bad_cmp = (c == TPWM_ZERO[W-1:0]) || (c > p);
    endfunction : bad_cmp

    assign start_me = start_wr && start_bits[CH]; // R1
    assign stop_me  = stop_wr && stop_bits[CH];
    assign up       = (st_q == TPWM_UP);
    assign crest    = up && (cnt_q == period_register); // R24
    assign trough   = (st_q == TPWM_DOWN) && (cnt_q == TPWM_ZERO[W-1:0]);

    // State follows the triangle: idle, rising half, falling half.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= TPWM_IDLE;
        end else if (ce) begin
            if (stop_me) begin
                st_q <= TPWM_IDLE;
            end else begin
                unique case (st_q)
                    TPWM_IDLE: begin
                        if (start_me) begin
                            st_q <= TPWM_UP; // R1
                        end
                    end
                    TPWM_UP: begin
                        if (crest) begin
                            st_q <= TPWM_DOWN; // R16
                        end
                    end
                    TPWM_DOWN: begin
                        if (trough) begin
                            st_q <= TPWM_UP;
                        end
                    end
                endcase
            end
        end
    end

    // Counter walks up to period, turns, walks down to zero.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= '0;
        end else if (ce && !stop_me) begin
            unique case (st_q)
                TPWM_IDLE: begin
                    if (start_me) begin
                        cnt_q <= '0; // R16
                    end
                end
                TPWM_UP: begin
                    if (crest) begin
                        cnt_q <= cnt_q - 1'b1; // R16
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                TPWM_DOWN: begin
                    if (trough) begin
                        cnt_q <= cnt_q + 1'b1;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
            endcase
        end
    end

    // Trough pulse tells software to reload the buffers.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            trough_interrupt <= 1'b0;
        end else if (ce) begin
            trough_interrupt <= trough; // R17
        end
    end

    // Crest pulse marks the turn from rising to falling.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            crest_interrupt <= 1'b0;
        end else if (ce) begin
            crest_interrupt <= crest; // R24
        end
    end

    // First half dead time reloads from its buffer at the trough.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dvu_q <= '0;
        end else if (ce) begin
            if (trough || force_xfer || start_me) begin
                dvu_q <= first_half_dead_time_buffer; // R21
            end
        end
    end

    // Second half dead time reloads from its buffer at the trough.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dvd_q <= '0;
        end else if (ce) begin
            if (trough || force_xfer || start_me) begin
                dvd_q <= second_half_dead_time_buffer; // R21
            end
        end
    end

    tpwm_buf #(
        .W (W)
    ) u_pos (
        .clk        (clk),
        .nrst       (nrst),
        .ce         (ce),
        .crest      (crest),
        .trough     (trough),
        .force_xfer (force_xfer), // R13
        .first_buf  (positive_first_buffer),
        .second_buf (positive_second_buffer),
        .cmp_q      (positive_compare)
    );

    tpwm_buf #(
        .W (W)
    ) u_neg (
        .clk        (clk),
        .nrst       (nrst),
        .ce         (ce),
        .crest      (crest), // R23
        .trough     (trough), // R12
        .force_xfer (force_xfer),
        .first_buf  (negative_first_buffer),
        .second_buf (negative_second_buffer),
        .cmp_q      (nb_cmp)
    );

    tpwm_dead #(
        .W (W)
    ) u_dead (
        .pos_cmp    (positive_compare),
        .dt_first   (dvu_q),
        .dt_second  (dvd_q),
        .neg_first  (nauto_up),
        .neg_second (nauto_dn),
        .dt_error   (dt_err)
    );

    // Auto mode recomputes the negative compare from every positive value.
    always_comb begin
        if (auto_dead_en) begin
            negative_compare = up ? nauto_up : nauto_dn; // R2
        end else begin
            negative_compare = nb_cmp;
        end
    end

    // Up half and down half use the compare valid at that time.
    assign pmatch = hit(positive_compare, cnt_q, period_register); // R19
    assign nmatch = hit(negative_compare, cnt_q, period_register); // R7

    // Next output levels: fixed at start and stop, toggled on each match that may_flip allows.
    always_comb begin
        pos_d = pos_q;
        neg_d = neg_q;
        if (stop_me || st_q == TPWM_IDLE) begin
            pos_d = TPWM_POS_START; // R14
            neg_d = TPWM_NEG_START; // R15
        end else if (auto_dead_en && dt_err && up) begin
            pos_d = TPWM_POS_START; // R22
            neg_d = TPWM_NEG_START; // R22
        end else begin
            if (pmatch && may_flip(pos_q, neg_q, !auto_dead_en)) begin
                pos_d = ~pos_q; // R14
            end
            if (nmatch && may_flip(neg_q, pos_q, !auto_dead_en)) begin
                neg_d = ~neg_q; // R15
            end
        end
    end

    // Positive level flop.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pos_q <= TPWM_POS_START;
        end else if (ce) begin
            pos_q <= pos_d;
        end
    end

    // Negative level flop.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            neg_q <= TPWM_NEG_START;
        end else if (ce) begin
            neg_q <= neg_d;
        end
    end

    // Positive pin is held off while the negative pin is on.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            positive_phase_pin <= TPWM_POS_START;
        end else if (ce) begin
            positive_phase_pin <= pos_d || !neg_d; // R18
        end
    end

    // Negative pin leaves its own flop so the driver sees no glitch.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            negative_phase_pin <= TPWM_NEG_START;
        end else if (ce) begin
            negative_phase_pin <= neg_d; // R9
        end
    end

    // Protection arms one cycle after counting begins.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            started_q <= 1'b0;
        end else if (ce) begin
            started_q <= (st_q != TPWM_IDLE);
        end
    end

    // Trip is sticky; a fresh start clears it, but a new fault wins.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            trip_q <= 1'b0;
        end else if (ce) begin
            if (started_q && auto_dead_en &&
                bad_cmp(positive_compare, period_register)) begin
                trip_q <= 1'b1; // R4
            end else if (start_me && st_q == TPWM_IDLE) begin
                trip_q <= 1'b0;
            end
        end
    end

    assign protect_trip    = trip_q;
    assign dead_time_error = dt_err;
    assign running         = (st_q != TPWM_IDLE);
    assign carrier_counter = cnt_q;
endmodule : tpwm_channel
`default_nettype wire

// [dv/tpwm_channel_props.sv]
// Concurrent checks on the ports of one triangle PWM channel.
`default_nettype none
module tpwm_channel_props
    import tpwm_pkg::*;
#(
    parameter int unsigned W  = TPWM_CW,
    parameter int unsigned CH = 0
) (
    input wire logic         clk,
    input wire logic         nrst,
    input wire logic         ce,
    input wire logic [2:0]   start_bits,
    input wire logic         start_wr,
    input wire logic [2:0]   stop_bits,
    input wire logic         stop_wr,
    input wire logic         auto_dead_en,
    input wire logic [W-1:0] period_register,
    input wire logic [W-1:0] positive_first_buffer,
    input wire logic         positive_phase_pin,
    input wire logic         negative_phase_pin,
    input wire logic         trough_interrupt,
    input wire logic         crest_interrupt,
    input wire logic         protect_trip,
    input wire logic         dead_time_error,
    input wire logic         running,
    input wire logic [W-1:0] carrier_counter,
    input wire logic [W-1:0] positive_compare,
    input wire logic [W-1:0] negative_compare
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_go;
        ce && start_wr && start_bits[CH] && !running && !stop_wr;
    endsequence
    sequence s_bad;
        (positive_compare == TPWM_ZERO || positive_compare > period_register);
    endsequence
    property p_start; s_go |=> running && carrier_counter == '0; endproperty
    a_start: assert property (p_start) else $error("start missed");
    property p_stop; ce && stop_wr && stop_bits[CH] |=> !running &&
        positive_phase_pin == TPWM_POS_START &&
        negative_phase_pin == TPWM_NEG_START; endproperty
    a_stop: assert property (p_stop) else $error("stop levels");
    property p_crest; running && ce && !stop_wr &&
        carrier_counter == period_register |=> crest_interrupt; endproperty
    a_crest: assert property (p_crest) else $error("no crest pulse");
    property p_pulse; crest_interrupt |=> !crest_interrupt; endproperty
    a_pulse: assert property (p_pulse) else $error("crest too long");
    property p_trough; trough_interrupt |->
        positive_compare == $past(positive_first_buffer); endproperty
    a_trough: assert property (p_trough) else $error("trough load");
    property p_overlap; running && auto_dead_en |->
        positive_phase_pin || negative_phase_pin; endproperty
    a_overlap: assert property (p_overlap) else $error("overlap");
    property p_dead; auto_dead_en && running && !dead_time_error |->
        negative_compare < positive_compare; endproperty
    a_dead: assert property (p_dead) else $error("dead value");
    property p_protect; running && auto_dead_en ##0 s_bad |->
        ##[0:2] protect_trip; endproperty
    a_protect: assert property (p_protect) else $error("no trip");
endmodule : tpwm_channel_props
bind tpwm_channel tpwm_channel_props #(.W(W), .CH(CH)) tpwm_channel_props_i (.*);
`default_nettype wire

// [dv/tpwm_gate_model.sv]
// Gate driver model: counts negative pin edges and overlap cycles.
`default_nettype none
module tpwm_gate_model (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        pos_pin,
    input  wire logic        neg_pin,
    output logic      [15:0] edges_q,
    output logic      [15:0] ovl_q
);
    logic neg_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            neg_q   <= 1'b0;
            edges_q <= 16'h0;
            ovl_q   <= 16'h0;
        end else begin
            neg_q   <= neg_pin;
            edges_q <= edges_q + 16'(neg_q != neg_pin);
            ovl_q   <= ovl_q + 16'(!pos_pin && !neg_pin);
        end
    end
endmodule : tpwm_gate_model
`default_nettype wire

// [dv/tpwm_channel_tb.sv]
// Self-checking bench for one triangle PWM channel.
`default_nettype none
module tpwm_channel_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tpwm_pkg::*;
    logic        clk = 1'b0, nrst = 1'b0, ce = 1'b1, auto_dead_en = 1'b0;
    logic        start_wr = 1'b0, stop_wr = 1'b0, force_xfer = 1'b0;
    logic [2:0]  start_bits = 3'h0, stop_bits = 3'h0;
    logic [31:0] period_register = 32'h14;
    logic [31:0] positive_first_buffer = 32'h0, positive_second_buffer = 32'h0;
    logic [31:0] negative_first_buffer = 32'h0, negative_second_buffer = 32'h0;
    logic [31:0] first_half_dead_time_buffer = 32'h2;
    logic [31:0] second_half_dead_time_buffer = 32'h3;
    logic        positive_phase_pin, negative_phase_pin, running, protect_trip;
    logic        trough_interrupt, crest_interrupt, dead_time_error;
    logic [31:0] carrier_counter, positive_compare, negative_compare;
    logic [15:0] edges, ovl;
    logic [63:0] exp_q[$];
    logic [63:0] got;
    int          fail_count = 0;
    int          total_checks = 0;
    bit          track = 1'b0;

    tpwm_channel #(.CH(0)) tpwm_channel_i (.*);
    tpwm_gate_model tpwm_gate_model_i (.clk(clk), .nrst(nrst),
        .pos_pin(positive_phase_pin), .neg_pin(negative_phase_pin),
        .edges_q(edges), .ovl_q(ovl));

    initial begin
        forever #4 clk = ~clk;
    end

    task automatic check(input logic [63:0] g, input logic [63:0] e);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : check

    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out

    task automatic wait_trough;
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (trough_interrupt !== 1'b1 && n < 200);
        if (trough_interrupt !== 1'b1) begin
            fail_count++;
            close_out();
        end
    endtask : wait_trough

    task automatic strobe(input int w, input logic [2:0] b);
        start_bits = b;
        stop_bits = b;
        {force_xfer, start_wr, stop_wr} = {w == 0, w == 1, w == 2};
        @(negedge clk);
        {force_xfer, start_wr, stop_wr} = 3'h0;
        @(negedge clk);
    endtask : strobe

    task automatic set_buf(input logic [31:0] a, b, x, y);
        {positive_first_buffer, positive_second_buffer} = {a, b};
        {negative_first_buffer, negative_second_buffer} = {x, y};
    endtask : set_buf

    function automatic logic [31:0] rnd();
        return 32'h2 + 32'($urandom % 17);
    endfunction : rnd

    always @(negedge clk) begin
        if (track && (crest_interrupt === 1'b1 || trough_interrupt === 1'b1)) begin
            got = {positive_compare, negative_compare};
            if (exp_q.size() > 0) begin
                check(got, exp_q.pop_front());
            end else begin
                check(got, 64'hF);
            end
        end
    end

    initial begin
        logic [31:0] c, d, e, f, tp, tn, v;
        logic [15:0] base;
        void'($urandom(26575));
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        {c, d, e, f} = {rnd(), rnd(), rnd(), rnd()};
        set_buf(c, d, e, f);
        strobe(0, 3'h0);
        check({positive_compare, negative_compare}, {c, e});
        {tp, tn} = {d, f};
        strobe(1, 3'h6);
        check({63'h0, running}, 64'h0);
        strobe(1, 3'h7);
        check({31'h0, running, carrier_counter}, {32'h1, 32'h1});
        track = 1'b1;
        for (int k = 0; k < 4; k++) begin
            exp_q.push_back({tp, tn});
            exp_q.push_back({c, e});
            {tp, tn} = {d, f};
            wait_trough();
            {c, d, e, f} = {rnd(), rnd(), rnd(), rnd()};
            set_buf(c, d, e, f);
        end
        @(posedge clk);
        track = 1'b0;
        for (int k = 0; k < 3; k++) begin
            v = (k == 0) ? period_register + 32'h5 : period_register;
            set_buf(c, d, (k == 2) ? 32'h0 : v, (k == 2) ? 32'h0 : v);
            wait_trough();
            wait_trough();
            base = edges;
            wait_trough();
            check({48'h0, edges - base}, {63'h0, k != 0});
        end
        strobe(2, 3'h1);
        check({61'h0, positive_phase_pin, negative_phase_pin, running},
            {61'h0, TPWM_POS_START, TPWM_NEG_START, 1'b0});
        auto_dead_en = 1'b1;
        set_buf(32'h9, 32'hB, 32'h0, 32'h0);
        strobe(0, 3'h0);
        strobe(1, 3'h1);
        base = ovl;
        wait_trough();
        wait_trough();
        ce = 1'b0;
        v = carrier_counter;
        repeat (4) @(negedge clk);
        check({32'h0, carrier_counter}, {32'h0, v});
        ce = 1'b1;
        check({48'h0, ovl}, {48'h0, base});
        set_buf(32'h0, 32'h0, 32'h0, 32'h0);
        for (int n = 0; n < 100 && protect_trip !== 1'b1; n++) @(negedge clk);
        check({63'h0, protect_trip}, 64'h1);
        close_out();
    end
endmodule : tpwm_channel_tb
`default_nettype wire
